// File: core/flash_section_guard.sv
// Overview of operation
// - Store triggers programming only from boot region
// - Boot-region store may target any page
// - Boot-size fuses set boundary; separate lock pairs
// - Fixed split decides halting behaviour
// - Read-while-write page: CPU runs, halting region readable
// - Halting-region page: CPU halted, nothing readable
// - Boot region always inside halting region
// - Busy flag reads one while region blocked
// - Region stays blocked until software clears flag
// - Lock bits only programmed; chip erase restores
// - General lock modes ignored by self-programming
// - App lock 10/00 refuses writes to app region
// - App lock 00/01 refuses boot loads from app
// - App lock 00/01 inhibits irq in app region
// - Boot lock 10/00 refuses writes to boot region
// - Boot lock 00/01 refuses app loads from boot
// - Boot lock 00/01 inhibits irq in boot region
`default_nettype none
module flash_section_guard
  import fsg_pkg::*;
#(
  parameter int unsigned OP_LEN = OP_CYCLES
)(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write address
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [3:0]   s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  // AXI4-Lite write response
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // AXI4-Lite read
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire logic [3:0]   s_axi_araddr,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // CPU program-memory port
  input  wire pm_req_s      cpu_req,
  input  wire logic         chip_erase,
  input  wire logic [1:0]   general_lock_mode,
  output logic              store_accept,
  output logic              load_grant,
  output logic              cpu_halt,
  output logic              fetch_rww_ok,
  output logic              irq_inhibit,
  output logic              prog_busy
);

  // Counter is OP_CNT_W bits wide; longer operations cannot be timed
  if (OP_LEN < 1 || OP_LEN > 65535) begin : g_op_len_check
    $error("OP_LEN out of range");
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [1:0]        app_lock_reg;      // {app_lock_hi, app_lock_lo}
  logic [1:0]        boot_lock_reg;     // {boot_lock_hi, boot_lock_lo}
  logic [1:0]        boot_size_reg;
  logic              ivec_boot_reg;
  logic              region_busy_flag;
  prog_state_e       state_reg;
  logic [OP_CNT_W-1:0] cnt_reg;
  logic              pc_in_boot;
  logic              target_in_boot;
  logic              target_halting;
  logic              write_ok;
  logic              read_ok;
  logic              irq_blk;
  logic              reenable;
  logic              wr_go;
  logic              aw_held;
  logic              w_held;
  logic [3:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;

  // ------------------------------------------------------------------
  // Region and lock decode
  // ------------------------------------------------------------------
  fsg_region_map u_map (
    .boot_size_fuses (boot_size_reg),
    .pc              (cpu_req.pc),
    .target          (cpu_req.target),
    .pc_in_boot      (pc_in_boot),
    .target_in_boot  (target_in_boot),
    .target_halting  (target_halting)
  );

  fsg_lock_check u_lock (
    .app_lock        (app_lock_reg),
    .boot_lock       (boot_lock_reg),
    .pc_in_boot      (pc_in_boot),
    .target_in_boot  (target_in_boot),
    .ivec_in_boot    (ivec_boot_reg),
    .write_ok        (write_ok),
    .read_ok         (read_ok),
    .irq_inhibit     (irq_blk)
  );

  // ------------------------------------------------------------------
  // CPU-facing grants
  // ------------------------------------------------------------------
  // general_lock_mode is deliberately not consulted
  assign store_accept = cpu_req.store && write_ok
                        && state_reg == ST_IDLE;
  // Halting-region reads stay serviced during a read-while-write op
  assign load_grant   = cpu_req.load && read_ok
                        && state_reg != ST_HALT
                        && (cpu_req.target >= HALT_START
                            || !region_busy_flag);
  assign cpu_halt     = state_reg == ST_HALT;
  assign fetch_rww_ok = !region_busy_flag && !cpu_halt;
  assign irq_inhibit  = irq_blk;
  assign prog_busy    = state_reg != ST_IDLE;

  // ------------------------------------------------------------------
  // Programming sequencer
  // ------------------------------------------------------------------
  // Halting-region targets stall the CPU; others keep it running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (store_accept) begin
            state_reg <= target_halting ? ST_HALT : ST_RWW;
            cnt_reg   <= OP_CNT_W'(OP_LEN - 1);
          end
        end
        ST_RWW, ST_HALT: begin
          if (cnt_reg == '0) state_reg <= ST_IDLE;
          else cnt_reg <= cnt_reg - 1'b1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Busy flag: set by any programming, cleared only by re-enable
  // issued while idle; a fresh start beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      region_busy_flag <= 1'b0;
    end else if (store_accept) begin
      region_busy_flag <= 1'b1;
    end else if (reenable && state_reg == ST_IDLE) begin
      region_busy_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign reenable      = wr_go && aw_addr_reg == SELF_PROG_CONTROL_OFS
                         && w_strb_reg[0]
                         && w_data_reg[REGION_READ_REENABLE_BIT];

  // Address and data caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held     <= 1'b0;
      w_held      <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held     <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held     <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg == STATUS_OFS) ? AXI_SLVERR : AXI_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Lock bits: software may only program (clear) them; chip erase
  // restores all to one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      app_lock_reg  <= LOCK_RESET[1:0];
      boot_lock_reg <= LOCK_RESET[3:2];
    end else if (chip_erase) begin
      app_lock_reg  <= LOCK_RESET[1:0];
      boot_lock_reg <= LOCK_RESET[3:2];
    end else if (wr_go && aw_addr_reg == LOCK_OFS && w_strb_reg[0]) begin
      app_lock_reg  <= app_lock_reg & w_data_reg[1:0];
      boot_lock_reg <= boot_lock_reg & w_data_reg[3:2];
    end
  end

  // Fuses and vector placement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_size_reg <= BOOT_SIZE_RESET;
      ivec_boot_reg <= 1'b0;
    end else if (wr_go && w_strb_reg[0] && aw_addr_reg == FUSE_OFS) begin
      boot_size_reg <= w_data_reg[1:0];
    end else if (wr_go && w_strb_reg[1]
                 && aw_addr_reg == SELF_PROG_CONTROL_OFS) begin
      ivec_boot_reg <= w_data_reg[IVEC_BOOT_BIT];
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // One-cycle answer after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      s_axi_rdata  <= '0;
      unique case ({s_axi_araddr[3:2], 2'b00})
        SELF_PROG_CONTROL_OFS: begin
          s_axi_rdata[REGION_BUSY_FLAG_BIT] <= region_busy_flag;
          s_axi_rdata[IVEC_BOOT_BIT]        <= ivec_boot_reg;
        end
        LOCK_OFS:   s_axi_rdata[3:0] <= {boot_lock_reg, app_lock_reg};
        FUSE_OFS:   s_axi_rdata[1:0] <= boot_size_reg;
        STATUS_OFS: s_axi_rdata[3:0] <= {general_lock_mode,
                                         state_reg};
        default:    s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_store_app_refused: assert property (@(posedge aclk) disable iff
    (!aresetn) (cpu_req.store && !pc_in_boot) |-> !store_accept)
    else $error("store from application region accepted");
  a_halt_region_halts: assert property (@(posedge aclk) disable iff
    (!aresetn) (store_accept && target_halting) |=> cpu_halt)
    else $error("halting-region op did not halt cpu");
  a_rww_keeps_running: assert property (@(posedge aclk) disable iff
    (!aresetn) (store_accept && !target_halting) |=> !cpu_halt)
    else $error("read-while-write op halted cpu");
  a_busy_after_start: assert property (@(posedge aclk) disable iff
    (!aresetn) store_accept |=> region_busy_flag)
    else $error("busy flag not set on start");
  a_busy_holds: assert property (@(posedge aclk) disable iff
    (!aresetn) (region_busy_flag && !reenable) |=> region_busy_flag)
    else $error("busy flag dropped without re-enable");
  a_boot_in_halting: assert property (@(posedge aclk) disable iff
    (!aresetn) pc_in_boot |-> cpu_req.pc >= HALT_START)
    else $error("boot region outside halting region");
  a_app_write_lock: assert property (@(posedge aclk) disable iff
    (!aresetn) (!app_lock_reg[0] && !target_in_boot) |-> !store_accept)
    else $error("locked application write accepted");
  a_boot_write_lock: assert property (@(posedge aclk) disable iff
    (!aresetn) (!boot_lock_reg[0] && target_in_boot) |-> !store_accept)
    else $error("locked boot write accepted");
  a_app_read_lock: assert property (@(posedge aclk) disable iff
    (!aresetn) (!app_lock_reg[1] && pc_in_boot && !target_in_boot)
    |-> !load_grant)
    else $error("locked application read granted");
  a_boot_read_lock: assert property (@(posedge aclk) disable iff
    (!aresetn) (!boot_lock_reg[1] && !pc_in_boot && target_in_boot)
    |-> !load_grant)
    else $error("locked boot read granted");
  a_lock_no_unset: assert property (@(posedge aclk) disable iff
    (!aresetn) !chip_erase |=> (app_lock_reg & ~$past(app_lock_reg))
    == 2'b00)
    else $error("lock bit returned without chip erase");

endmodule : flash_section_guard
`default_nettype wire

// File: core/fsg_pkg.sv
`default_nettype none
package fsg_pkg;

  // ------------------------------------------------------------------
  // Flash geometry and timing
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 14;  // Word address width
  localparam int unsigned PAGE_BITS       = 6;   // Words per page, log2
  localparam int unsigned PAGE_W          = ADDR_W - PAGE_BITS;
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned OP_TIME_US      = 4;   // Page erase/write time
  localparam int unsigned OP_CYCLES       = OP_TIME_US * CLK_MHZ;
  localparam int unsigned OP_CNT_W        = 16;
  // Fixed split: writing the upper quarter of flash halts the CPU; it stays readable during other writes
  localparam logic [ADDR_W-1:0] HALT_START = 14'h3000;
  // Boot region start per boot-size code; boot region always in upper
  // quarter, so always inside the halting region
  localparam logic [ADDR_W-1:0] BOOT_START_00 = 14'h3000;
  localparam logic [ADDR_W-1:0] BOOT_START_01 = 14'h3800;
  localparam logic [ADDR_W-1:0] BOOT_START_10 = 14'h3C00;
  localparam logic [ADDR_W-1:0] BOOT_START_11 = 14'h3E00;

  // ------------------------------------------------------------------
  // AXI4-Lite register map
  // ------------------------------------------------------------------
  localparam logic [3:0] SELF_PROG_CONTROL_OFS = 4'h0;
  localparam logic [3:0] LOCK_OFS              = 4'h4;
  localparam logic [3:0] FUSE_OFS              = 4'h8;
  localparam logic [3:0] STATUS_OFS            = 4'hC;
  // Control register fields
  localparam int unsigned REGION_READ_REENABLE_BIT = 4;
  localparam int unsigned REGION_BUSY_FLAG_BIT     = 6;
  localparam int unsigned IVEC_BOOT_BIT            = 8;
  localparam logic [3:0]  LOCK_RESET               = 4'hF;
  localparam logic [1:0]  BOOT_SIZE_RESET          = 2'h0;
  localparam logic [1:0]  AXI_OKAY                 = 2'h0;
  localparam logic [1:0]  AXI_SLVERR               = 2'h2;

  // Program-memory request from the CPU core
  typedef struct packed {
    logic              store;   // Erase/write trigger
    logic              load;    // Program-memory load
    logic [ADDR_W-1:0] pc;      // Address of executing instruction
    logic [ADDR_W-1:0] target;  // Flash word addressed
  } pm_req_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RWW  = 2'b01,
    ST_HALT = 2'b10
  } prog_state_e;

endpackage : fsg_pkg
`default_nettype wire

// File: core/fsg_region_map.sv
`default_nettype none
module fsg_region_map
  import fsg_pkg::*;
(
  // Configuration
  input  wire logic [1:0]        boot_size_fuses,
  // Addresses to classify
  input  wire logic [ADDR_W-1:0] pc,
  input  wire logic [ADDR_W-1:0] target,
  // Classification
  output logic                   pc_in_boot,
  output logic                   target_in_boot,
  output logic                   target_halting
);

  // ------------------------------------------------------------------
  // Boundary decode
  // ------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] boot_start(input logic [1:0] s);
    unique case (s)
      2'b00: boot_start = BOOT_START_00;
      2'b01: boot_start = BOOT_START_01;
      2'b10: boot_start = BOOT_START_10;
      2'b11: boot_start = BOOT_START_11;
    endcase
  endfunction : boot_start

  // Fuse-selected boundary, and the fixed halting split
  assign pc_in_boot     = pc >= boot_start(boot_size_fuses);
  assign target_in_boot = target >= boot_start(boot_size_fuses);
  assign target_halting = target >= HALT_START;

endmodule : fsg_region_map
`default_nettype wire

// File: core/fsg_lock_check.sv
`default_nettype none
module fsg_lock_check
  import fsg_pkg::*;
(
  // Lock pairs, 1 = unprogrammed
  input  wire logic [1:0] app_lock,
  input  wire logic [1:0] boot_lock,
  // Classification
  input  wire logic       pc_in_boot,
  input  wire logic       target_in_boot,
  input  wire logic       ivec_in_boot,
  // Verdicts
  output logic            write_ok,
  output logic            read_ok,
  output logic            irq_inhibit
);

  // ------------------------------------------------------------------
  // Lock decode
  // ------------------------------------------------------------------
  // Writes blocked when hi bit stays 1 and lo is 0, or both 0
  function automatic logic no_write(input logic [1:0] l);
    no_write = ~l[0];
  endfunction : no_write

  // Cross-region reads blocked when hi bit programmed
  function automatic logic no_read(input logic [1:0] l);
    no_read = ~l[1];
  endfunction : no_read

  // Write: only from boot region, to any page subject to its lock
  assign write_ok = pc_in_boot
    && !(target_in_boot ? no_write(boot_lock)
                        : no_write(app_lock));
  // Read: compare executing region with target region
  assign read_ok = (pc_in_boot == target_in_boot)
    || (pc_in_boot ? !no_read(app_lock)
                   : !no_read(boot_lock));
  // Interrupt gating when vectors live in the other region
  assign irq_inhibit = (ivec_in_boot && !pc_in_boot
                        && no_read(app_lock))
                    || (!ivec_in_boot && pc_in_boot
                        && no_read(boot_lock));

endmodule : fsg_lock_check
`default_nettype wire

// File: sim/fsg_cpu_model.sv
`default_nettype none
module fsg_cpu_model
  import fsg_pkg::*;
(
  // Clock and guard status
  input  wire logic              aclk,
  input  wire logic              fetch_rww_ok,
  // Commands from the bench
  input  wire logic              cmd_store,
  input  wire logic              cmd_load,
  input  wire logic [ADDR_W-1:0] cmd_pc,
  input  wire logic [ADDR_W-1:0] cmd_target,
  // Program-memory request
  output pm_req_s                cpu_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] idle_pattern = 14'h2AAA;

  // Idle target flips every cycle so a stale address never looks valid
  always_ff @(posedge aclk) begin
    idle_pattern <= ~idle_pattern;
  end

  // Software keeps loads off a blocked read-while-write region
  always_comb begin
    cpu_req.store  = cmd_store;
    cpu_req.load   = cmd_load & (fetch_rww_ok | (cmd_target >= HALT_START));
    cpu_req.pc     = cmd_pc;
    cpu_req.target = (cmd_store | cmd_load) ? cmd_target : idle_pattern;
  end
endmodule : fsg_cpu_model
`default_nettype wire

// File: sim/flash_section_guard_tb_top.sv
`default_nettype none
module flash_section_guard_tb_top
  import fsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        fl;
    logic [31:0] mask;
    logic [31:0] val;
  } exp_s;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  localparam int unsigned OPL    = 4;  // Short op keeps the run brief
  localparam logic [5:0]  F_ACC  = 6'h20, F_LD = 6'h10, F_HALT = 6'h08;
  localparam logic [5:0]  F_FETCH = 6'h04, F_IRQ = 6'h02, F_BUSY = 6'h01;
  localparam logic [31:0] BUSY_W = 32'h1 << REGION_BUSY_FLAG_BIT;
  localparam logic [31:0] RE_W   = 32'h1 << REGION_READ_REENABLE_BIT;
  localparam logic [31:0] IVEC_W = 32'h1 << IVEC_BOOT_BIT;
  localparam logic [7:0]  LOCKS  = 8'h4B;  // Lock pairs 11, 10, 00, 01
  logic        aclk = 1'b0, aresetn = 1'b0, chip_erase = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, probe = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'hE8C7;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, general_lock_mode = 2'h0;
  pm_req_s     cpu_req;
  logic        store_accept, load_grant, cpu_halt;
  logic        fetch_rww_ok, irq_inhibit, prog_busy;
  logic        cmd_store = 1'b0, cmd_load = 1'b0;
  logic [ADDR_W-1:0] cmd_pc = 14'h0, cmd_target = 14'h0;
  exp_s        notes[$];
  int          fails = 0, samples_checked = 0, cycles = 0;

  flash_section_guard #(.OP_LEN(OPL)) i_flash_section_guard (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .cpu_req, .chip_erase,
    .general_lock_mode, .store_accept, .load_grant, .cpu_halt,
    .fetch_rww_ok, .irq_inhibit, .prog_busy);
  fsg_cpu_model i_fsg_cpu_model (.aclk, .fetch_rww_ok, .cmd_store,
    .cmd_load, .cmd_pc, .cmd_target, .cpu_req);

  // Free-running 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [ADDR_W-1:0] boot_start(input int k);
    case (k)
      0: return BOOT_START_00;
      1: return BOOT_START_01;
      2: return BOOT_START_10;
      default: return BOOT_START_11;
    endcase
  endfunction : boot_start
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // A wrong kind of note also catches an empty queue in the flag check
  task automatic cmp_word(input exp_s e, input logic [31:0] got);
    samples_checked++;
    if (e.fl !== 1'b0 || (got & e.mask) !== e.val) begin
      fails++;
      $display("ERROR %0t: word %h expected %h", $time, got, e.val);
    end
  endtask : cmp_word
  task automatic cmp_flags(input exp_s e, input logic [5:0] got);
    samples_checked++;
    if (e.fl !== 1'b1 || (got & e.mask[5:0]) !== e.val[5:0]) begin
      fails++;
      $display("ERROR %0t: flags %b expected %b", $time, got, e.val[5:0]);
    end
  endtask : cmp_flags
  task automatic note(input logic f, input logic [31:0] m, v);
    notes.push_back(exp_s'{f, m, v});
  endtask : note
  // Each probe holds the CPU request for one cycle and notes the flags
  task automatic pr(input logic st, ld, input logic [ADDR_W-1:0] pc, tg,
                    input logic [5:0] m, v);
    cmd_store <= st;
    cmd_load <= ld;
    cmd_pc <= pc;
    cmd_target <= tg;
    probe <= 1'b1;
    rnd = lfsr(rnd);
    general_lock_mode <= rnd[1:0];
    note(1'b1, {26'h0, m}, {26'h0, v});
    @(posedge aclk);
  endtask : pr
  task automatic rest();
    cmd_store <= 1'b0;
    cmd_load <= 1'b0;
    probe <= 1'b0;
    @(posedge aclk);
  endtask : rest
  task automatic erase();
    chip_erase <= 1'b1;
    @(posedge aclk);
    chip_erase <= 1'b0;
    @(posedge aclk);
  endtask : erase
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw, w;
    note(1'b0, 32'h3, {30'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] m, v);
    note(1'b0, m | 32'hC000_0000, v);  // Top bits carry the response
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Whole page operation, busy flag check and re-enable
  task automatic run_op(input logic [ADDR_W-1:0] pc, tg, input logic h);
    logic [5:0] hv;
    hv = h ? (F_HALT | F_BUSY) : F_BUSY;
    pr(1'b1, 1'b0, pc, tg, F_ACC, F_ACC);
    repeat (OPL - 1)
      pr(1'b1, 1'b0, pc, tg, F_ACC | F_HALT | F_FETCH | F_BUSY, hv);
    // Last busy cycle: a load from the halting region
    pr(1'b0, 1'b1, pc, pc, F_LD | F_HALT | F_BUSY,
       hv | (h ? 6'h00 : F_LD));
    pr(1'b0, 1'b0, pc, tg, F_HALT | F_FETCH | F_BUSY, 6'h00);
    rest();
    rd(SELF_PROG_CONTROL_OFS, BUSY_W, BUSY_W);
    wr(SELF_PROG_CONTROL_OFS, RE_W, AXI_OKAY);
    rd(SELF_PROG_CONTROL_OFS, BUSY_W, 32'h0);
    pr(1'b0, 1'b0, pc, tg, F_FETCH, F_FETCH);
    rest();
  endtask : run_op
  task automatic try_store(input logic [ADDR_W-1:0] pc, tg, input logic ok);
    if (ok) run_op(pc, tg, tg >= HALT_START);
    else begin
      pr(1'b1, 1'b0, pc, tg, F_ACC, 6'h00);
      rest();
    end
  endtask : try_store

  // Oldest note pairs with each result as it shows
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready)
      cmp_word(notes.pop_front(), {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready)
      cmp_word(notes.pop_front(),
               {s_axi_rresp | s_axi_rdata[31:30], s_axi_rdata[29:0]});
    if (probe) cmp_flags(notes.pop_front(), {store_accept, load_grant,
      cpu_halt, fetch_rww_ok, irq_inhibit, prog_busy});
  end
  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SELF_PROG_CONTROL_OFS, BUSY_W | IVEC_W, 32'h0);
    rd(LOCK_OFS, 32'hF, {28'h0, LOCK_RESET});
    rd(FUSE_OFS, 32'h3, {30'h0, BOOT_SIZE_RESET});
    rd(STATUS_OFS, 32'hF, 32'h0);
    wr(STATUS_OFS, 32'h0, AXI_SLVERR);
    $display("test reset done");
    run_op(BOOT_START_00, 14'h0200, 1'b0);
    run_op(BOOT_START_00, 14'h3100, 1'b1);
    try_store(14'h0100, 14'h0200, 1'b0);
    $display("test section done");
    wr(LOCK_OFS, 32'h3, AXI_OKAY);
    wr(LOCK_OFS, 32'hF, AXI_OKAY);
    rd(LOCK_OFS, 32'hF, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(FUSE_OFS, k, AXI_OKAY);
      rd(FUSE_OFS, 32'h3, k);
      pr(1'b0, 1'b1, boot_start(k) - 14'h1, boot_start(k), F_LD, 6'h00);
      pr(1'b0, 1'b1, boot_start(k) - 14'h1, boot_start(k) - 14'h1, F_LD, F_LD);
      rest();
    end
    run_op(BOOT_START_11, 14'h3100, 1'b1);
    erase();
    rd(LOCK_OFS, 32'hF, 32'hF);
    wr(FUSE_OFS, 32'h0, AXI_OKAY);
    $display("test fuse done");
    for (int i = 0; i < 4; i++) begin
      logic [1:0] v;
      v = LOCKS[2*i +: 2];
      erase();
      wr(LOCK_OFS, {28'h0, v, v}, AXI_OKAY);
      wr(LOCK_OFS, 32'hF, AXI_OKAY);
      rd(LOCK_OFS, 32'hF, {28'h0, v, v});
      try_store(BOOT_START_00, 14'h0100, v[0]);
      try_store(BOOT_START_00, 14'h3100, v[0]);
      pr(1'b0, 1'b1, BOOT_START_00, 14'h0100, F_LD, v[1] ? F_LD : 6'h00);
      pr(1'b0, 1'b1, 14'h0100, 14'h3100, F_LD, v[1] ? F_LD : 6'h00);
      rest();
      wr(SELF_PROG_CONTROL_OFS, IVEC_W, AXI_OKAY);
      pr(1'b0, 1'b0, 14'h0100, 14'h0, F_IRQ, v[1] ? 6'h00 : F_IRQ);
      pr(1'b0, 1'b0, BOOT_START_00, 14'h0, F_IRQ, 6'h00);
      rest();
      wr(SELF_PROG_CONTROL_OFS, 32'h0, AXI_OKAY);
      pr(1'b0, 1'b0, BOOT_START_00, 14'h0, F_IRQ, v[1] ? 6'h00 : F_IRQ);
      pr(1'b0, 1'b0, 14'h0100, 14'h0, F_IRQ, 6'h00);
      rest();
      rd(STATUS_OFS, 32'hC, {28'h0, general_lock_mode, 2'h0});
    end
    $display("test locks done");
    results();
  end
endmodule : flash_section_guard_tb_top
`default_nettype wire
